//--- sim/bdvs_ctrl_bench.sv
module bdvs_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  wire  [7:0]  addr, wdata, rdata, phase, freq;
  wire         wr, rd, sby, en;
  wire  [23:0] code;
  wire  [3:0]  on, slp, mask;
  wire  [10:0] mv;
  logic [7:0]  v;
  logic [1:0]  f;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  always #50 clock_i = ~clock_i;
  bdvs_host host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .standby_o(sby), .en_o(en));
  bdvs_ctrl uut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .standby_request_i(sby), .enable_i(en),
    .out_code_o(code), .chan_on_o(on), .chan_sleep_o(slp), .ocp_mask_o(mask),
    .clock_phase_o(phase), .switch_freq_o(freq), .channel_one_mv_o(mv));
  task chk(input string s, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // bounded wait for channel one to land; mask must drop after
  task wc(input logic [5:0] t);
    n = 0;
    while (code[5:0] !== t && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    repeat (2) @(negedge clock_i);
    chk("code", t, code[5:0]);
    chk("mask", 0, mask[0]);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    chk("phase", 8'he4, phase);
    chk("freq", 0, freq);
    host.rd(8'h32, v);
    chk("conf", 8'h40, v);
    host.rd(8'h00, v);
    chk("unmapped", 0, v);
    host.pins(1'b0, 1'b1);
    wc(6'h0d);
    // alternate direction so both up and down ramps are timed
    for (int r = 0; r < 4; r++) begin
      f = (r == 3) ? 2'h2 : 2'(r);
      host.wr(8'h32, {2'(r), 2'(r), 2'(r), 2'h0});
      host.wr(8'h2e, r[0] ? 8'h0d : 8'h0f);
      wc(r[0] ? 6'h0d : 6'h0f);
      chk("ramp time", 1, n >= (20 << r) && n <= (40 << r) + 5);
      chk("phase", 12'(r), phase[1:0]);
      chk("freq", f, freq[1:0]);
    end
    host.wr(8'h2f, 8'h10);
    host.pins(1'b1, 1'b1);
    wc(6'h10);
    host.wr(8'h2e, 8'h05);
    host.pins(1'b0, 1'b1);
    wc(6'h0d);
    host.wr(8'h30, 8'h0e);
    // keep bit with forced pwm so turn-off sleeps and ramps up to the sleep field
    host.wr(8'h31, 8'h25);
    host.pins(1'b0, 1'b0);
    wc(6'h0e);
    chk("sleep", 1, slp[0]);
    chk("off", 0, on[1]);
    chk("mv", 12'd650, mv);
    host.wr(8'h32, 8'h00);
    host.wr(8'h30, 8'h3f);
    wc(6'h3f);
    chk("mv", 12'd1875, mv);
    end_of_test;
  end
endmodule

//--- sim/bdvs_ctrl_sva.sv
module bdvs_chk (
  input logic        clock_i,          // clock
  input logic        nrst_i,           // reset, active low
  input logic [7:0]  addr_i,           // address
  input logic [7:0]  wdata_i,          // write data
  input logic        wr_i,             // write strobe
  input logic [23:0] out_code_o,       // live codes
  input logic [3:0]  chan_on_o,        // regulating
  input logic [3:0]  chan_sleep_o,     // sleeping
  input logic [3:0]  ocp_mask_o,       // ramp running
  input logic [7:0]  clock_phase_o,    // phase codes
  input logic [7:0]  switch_freq_o,    // frequency codes
  input logic [10:0] channel_one_mv_o  // channel one mV
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire [5:0] c0 = out_code_o[5:0];
  // the jump to the floor while the channel is off is not a ramp step
  chk_one_step: assert property (
    $past(chan_on_o[0]) && chan_on_o[0] && $changed(c0) |->
    (c0 == $past(c0) + 6'h01 || c0 == $past(c0) - 6'h01)) else $error("ramp step not one code");
  chk_step_gap: assert property (
    $past(chan_on_o[0]) && chan_on_o[0] && $changed(c0) |=>
    (!chan_on_o[0] || $stable(c0))[*8]) else $error("ramp steps too close");
  chk_mask_ramp: assert property (
    $past(chan_on_o[0]) && chan_on_o[0] && $changed(c0) |->
    ocp_mask_o[0] || $past(ocp_mask_o[0])) else $error("step without mask");
  chk_land_hold: assert property (
    $fell(ocp_mask_o[0]) && chan_on_o[0] |-> $stable(c0)) else $error("mask fell off target");
  chk_mv_decode: assert property (
    c0 >= 6'h0d && $stable(c0) ##1 $stable(c0) |->
    {1'b0, channel_one_mv_o} == 12'd300 + 12'd25 * c0) else $error("mv decode wrong");
  chk_freq_legal: assert property (
    switch_freq_o[1:0] != 2'h3) else $error("reserved frequency code");
  chk_sleep_on: assert property (
    (chan_sleep_o & ~chan_on_o) == 4'h0) else $error("sleep while off");
  chk_phase_wr: assert property (
    wr_i && addr_i == 8'h32 |-> ##2 clock_phase_o[1:0] == $past(wdata_i[5:4], 2))
    else $error("phase not taken");
  cov_ramp: cover property ($rose(ocp_mask_o[0]));
  cov_sleep: cover property ($rose(chan_sleep_o[0]));
  cov_rsvd: cover property (wr_i && addr_i == 8'h32 && wdata_i[3:2] == 2'h3);
endmodule

bind bdvs_ctrl bdvs_chk chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .out_code_o(out_code_o), .chan_on_o(chan_on_o),
  .chan_sleep_o(chan_sleep_o), .ocp_mask_o(ocp_mask_o),
  .clock_phase_o(clock_phase_o), .switch_freq_o(switch_freq_o),
  .channel_one_mv_o(channel_one_mv_o)
);

//--- sim/bdvs_host.sv
module bdvs_host (
  input  wire logic       clock_i,    // bus clock
  input  wire logic [7:0] rdata_i,    // read data
  output logic [7:0]      addr_o,     // address
  output logic [7:0]      wdata_o,    // write data
  output logic            wr_o,       // write strobe
  output logic            rd_o,       // read strobe
  output logic            standby_o,  // standby pin
  output logic            en_o        // enable pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    standby_o = 1'b0;
    en_o = 1'b0;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
  endtask
  // data only stands in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    @(negedge clock_i);
    v = rdata_i;
  endtask
  task pins(input logic s, input logic e);
    @(posedge clock_i);
    standby_o <= s;
    en_o <= e;
  endtask
endmodule

//--- src/bdvs_ctrl.v
// Operation
// - normal target from normal field, ramped
// - standby input picks standby field
// - standby entry/exit ramps at rate field
// - sleep entry ramps to sleep field
// - 25 mV per 2/4/8/16 us interval
// - rate field resets to code 01
// - overcurrent masked while ramp runs
// - phase codes give 0/90/180/270 degrees
// - power-up phases 0, 90, 180, 270
// - frequency codes 1/2/4 MHz, 11 reserved
// - any phase with any frequency
// - channel one: 0.625 V at code 0d plus 25 mV/code above it
// - field writes change that mode's voltage
// - turn-off: sleep if keep bit, else off
`include "bdvs_map.vh"

module bdvs_ctrl (
  input  wire        clock_i,            // 10 MHz system clock
  input  wire        nrst_i,             // async reset, active low
  input  wire [7:0]  addr_i,             // register address
  input  wire [7:0]  wdata_i,            // register write data
  input  wire        wr_i,               // write strobe
  input  wire        rd_i,               // read strobe
  output reg  [7:0]  rdata_o,            // read data, cycle after strobe
  input  wire        standby_request_i,  // standby pin
  input  wire        enable_i,           // enable pin, low is turn-off
  output wire [23:0] out_code_o,         // live set point code per channel
  output wire [3:0]  chan_on_o,          // channel regulating
  output wire [3:0]  chan_sleep_o,       // channel in sleep
  output wire [3:0]  ocp_mask_o,         // overcurrent mask, ramp running
  output reg  [7:0]  clock_phase_o,      // phase code per channel
  output reg  [7:0]  switch_freq_o,      // frequency code per channel
  output reg  [10:0] channel_one_mv_o    // channel one output in mV
);

  reg [5:0] normal_setpoint_r  [0:3];
  reg [5:0] standby_setpoint_r [0:3];
  reg [5:0] sleep_setpoint_r   [0:3];
  reg [3:0] switch_mode_r      [0:3];
  reg       sleep_keep_on_r    [0:3];
  reg       ilim_r             [0:3];
  reg       spare_r            [0:3];
  reg [1:0] switch_freq_sel_r  [0:3];
  reg [1:0] clock_phase_sel_r  [0:3];
  reg [1:0] ramp_rate_select_r [0:3];

  reg [2:0] standby_request_sync_r;
  reg [2:0] en_sync_r;
  reg       standby_request_lvl_r;
  reg       en_lvl_r;
  reg [4:0] base_cnt_r;
  reg       base_tick_r;
  reg [7:0] rd_nxt;
  reg [7:0] cb;
  integer   i;
  // each process owns its loop index, so no variable has two drivers
  integer   j;
  integer   k;

  wire [5:0] cur_code [0:3];

  // pins come from outside: three flops, accept when last two agree
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      standby_request_sync_r <= 3'h0;
      en_sync_r   <= 3'h0;
      standby_request_lvl_r  <= 1'b0;
      en_lvl_r    <= 1'b0;
    end else begin
      standby_request_sync_r <= {standby_request_sync_r[1:0], standby_request_i};
      en_sync_r   <= {en_sync_r[1:0], enable_i};
      if (standby_request_sync_r[1] == standby_request_sync_r[2]) begin
        standby_request_lvl_r <= standby_request_sync_r[2];
      end
      if (en_sync_r[1] == en_sync_r[2]) begin
        en_lvl_r <= en_sync_r[2];
      end
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      base_cnt_r  <= 5'h00;
      base_tick_r <= 1'b0;
    end else if (base_cnt_r == `BDVS_BASE_LAST) begin
      base_cnt_r  <= 5'h00;
      base_tick_r <= 1'b1;
    end else begin
      base_cnt_r  <= base_cnt_r + 5'h01;
      base_tick_r <= 1'b0;
    end
  end

  // register writes
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (i = 0; i < `BDVS_NCH; i = i + 1) begin
        normal_setpoint_r[i]  <= `BDVS_RST_CODE;
        standby_setpoint_r[i] <= `BDVS_RST_CODE;
        sleep_setpoint_r[i]   <= `BDVS_RST_CODE;
        switch_mode_r[i]      <= `BDVS_RST_MODE;
        sleep_keep_on_r[i]    <= 1'b0;
        ilim_r[i]             <= 1'b0;
        spare_r[i]            <= 1'b0;
        switch_freq_sel_r[i]  <= `BDVS_RST_FREQ;
        clock_phase_sel_r[i]  <= i[1:0];
        ramp_rate_select_r[i] <= `BDVS_RST_RATE;
      end
    end else if (wr_i) begin
      for (i = 0; i < `BDVS_NCH; i = i + 1) begin
        if (addr_i == (`BDVS_CH_BASE + `BDVS_CH_STRIDE * i[7:0] + `BDVS_OFS_NORM)) begin
          normal_setpoint_r[i] <= wdata_i[5:0];
        end else if (addr_i == (`BDVS_CH_BASE + `BDVS_CH_STRIDE * i[7:0]
                                + `BDVS_OFS_STANDBY_REQUEST)) begin
          standby_setpoint_r[i] <= wdata_i[5:0];
        end else if (addr_i == (`BDVS_CH_BASE + `BDVS_CH_STRIDE * i[7:0]
                                + `BDVS_OFS_SLEEP)) begin
          sleep_setpoint_r[i] <= wdata_i[5:0];
        end else if (addr_i == (`BDVS_CH_BASE + `BDVS_CH_STRIDE * i[7:0]
                                + `BDVS_OFS_MODE)) begin
          switch_mode_r[i]   <= wdata_i[`BDVS_MODE_LO:`BDVS_MODE_HI];
          sleep_keep_on_r[i] <= wdata_i[`BDVS_KEEP_BIT];
        end else if (addr_i == (`BDVS_CH_BASE + `BDVS_CH_STRIDE * i[7:0]
                                + `BDVS_OFS_CONF)) begin
          ilim_r[i]             <= wdata_i[`BDVS_ILIM_BIT];
          spare_r[i]            <= wdata_i[`BDVS_SPARE_BIT];
          clock_phase_sel_r[i]  <= wdata_i[`BDVS_PHASE_HI:`BDVS_PHASE_LO];
          ramp_rate_select_r[i] <= wdata_i[`BDVS_RATE_HI:`BDVS_RATE_LO];
          // reserved frequency code keeps the old one
          if (wdata_i[`BDVS_FREQ_HI:`BDVS_FREQ_LO] != `BDVS_FREQ_RSVD) begin
            switch_freq_sel_r[i] <= wdata_i[`BDVS_FREQ_HI:`BDVS_FREQ_LO];
          end
        end
      end
    end
  end

  // read mux, unmapped reads as zero
  always @* begin
    rd_nxt = 8'h00;
    cb     = `BDVS_CH_BASE;
    for (j = 0; j < `BDVS_NCH; j = j + 1) begin
      if (addr_i == cb + `BDVS_OFS_NORM) begin
        rd_nxt = {2'h0, normal_setpoint_r[j]};
      end else if (addr_i == cb + `BDVS_OFS_STANDBY_REQUEST) begin
        rd_nxt = {2'h0, standby_setpoint_r[j]};
      end else if (addr_i == cb + `BDVS_OFS_SLEEP) begin
        rd_nxt = {2'h0, sleep_setpoint_r[j]};
      end else if (addr_i == cb + `BDVS_OFS_MODE) begin
        rd_nxt = {2'h0, sleep_keep_on_r[j], 1'b0, switch_mode_r[j]};
      end else if (addr_i == cb + `BDVS_OFS_CONF) begin
        rd_nxt = {ramp_rate_select_r[j], clock_phase_sel_r[j],
                  switch_freq_sel_r[j], spare_r[j], ilim_r[j]};
      end else if (addr_i == `BDVS_CODE_BASE + j[7:0]) begin
        rd_nxt = {2'h0, cur_code[j]};
      end
      cb = cb + `BDVS_CH_STRIDE;
    end
    if (addr_i == `BDVS_STATUS) begin
      rd_nxt = {chan_on_o, ocp_mask_o};
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rd_nxt;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // phase and frequency codes to the clock generator
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clock_phase_o <= `BDVS_RST_PHASES;
      switch_freq_o <= 8'h00;
    end else begin
      for (k = 0; k < `BDVS_NCH; k = k + 1) begin
        clock_phase_o[2*k +: 2] <= clock_phase_sel_r[k];
        switch_freq_o[2*k +: 2] <= switch_freq_sel_r[k];
      end
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      channel_one_mv_o <= `BDVS_MV_BASE;
    end else begin
      channel_one_mv_o <= `BDVS_MV_BASE + `BDVS_MV_STEP
                          * ({5'h00, cur_code[0]} - {5'h00, `BDVS_CH1_FLOOR});
    end
  end

  genvar g;
  generate
    for (g = 0; g < `BDVS_NCH; g = g + 1) begin : ch
      wire [5:0] floor_code = (g == 0) ? `BDVS_CH1_FLOOR : `BDVS_ANY_FLOOR;
      reg  [5:0] cur_r;
      reg  [3:0] tcnt_r;
      reg        busy_r;
      reg        on_r;
      reg        slp_r;
      reg  [5:0] pick;
      reg  [5:0] tgt;
      reg  [3:0] span;

      always @* begin
        pick = standby_request_lvl_r ? standby_setpoint_r[g] : normal_setpoint_r[g];
        if (!en_lvl_r) begin
          pick = sleep_setpoint_r[g];
        end
        // undefined low codes are raised to the floor
        tgt = (pick < floor_code) ? floor_code : pick;
        // interval is base tick times 1, 2, 4 or 8
        span = 4'h1 << ramp_rate_select_r[g];
      end

      always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cur_r  <= `BDVS_RST_CODE;
          tcnt_r <= 4'h0;
          busy_r <= 1'b0;
          on_r   <= 1'b0;
          slp_r  <= 1'b0;
        end else if (!en_lvl_r && !sleep_keep_on_r[g]) begin
          // turn-off without keep bit: channel off
          cur_r  <= floor_code;
          tcnt_r <= 4'h0;
          busy_r <= 1'b0;
          on_r   <= 1'b0;
          slp_r  <= 1'b0;
        end else begin
          // keep bit: stay on in sleep
          on_r  <= 1'b1;
          slp_r <= !en_lvl_r;
          if (cur_r == tgt) begin
            tcnt_r <= 4'h0;
            busy_r <= 1'b0;
          end else begin
            busy_r <= 1'b1;
            if (base_tick_r) begin
              if (tcnt_r + 4'h1 >= span) begin
                tcnt_r <= 4'h0;
                cur_r  <= (cur_r < tgt) ? cur_r + 6'h01 : cur_r - 6'h01;
              end else begin
                tcnt_r <= tcnt_r + 4'h1;
              end
            end
          end
        end
      end

      assign cur_code[g]       = cur_r;
      assign out_code_o[6*g +: 6] = cur_r;
      assign chan_on_o[g]      = on_r;
      assign chan_sleep_o[g]   = slp_r;
      assign ocp_mask_o[g]     = busy_r;
    end
  endgenerate

endmodule

//--- src/bdvs_map.vh
`ifndef BDVS_MAP_VH
`define BDVS_MAP_VH

// channel register window
`define BDVS_NCH         4
`define BDVS_CH_BASE     8'h2e
`define BDVS_CH_STRIDE   8'h05
`define BDVS_OFS_NORM    8'h00
`define BDVS_OFS_STANDBY_REQUEST    8'h01
`define BDVS_OFS_SLEEP   8'h02
`define BDVS_OFS_MODE    8'h03
`define BDVS_OFS_CONF    8'h04

// status window
`define BDVS_CODE_BASE   8'h40
`define BDVS_STATUS      8'h44

// mode register fields
`define BDVS_MODE_LO     3
`define BDVS_MODE_HI     0
`define BDVS_KEEP_BIT    5

// conf register fields
`define BDVS_ILIM_BIT    0
`define BDVS_SPARE_BIT   1
`define BDVS_FREQ_HI     3
`define BDVS_FREQ_LO     2
`define BDVS_PHASE_HI    5
`define BDVS_PHASE_LO    4
`define BDVS_RATE_HI     7
`define BDVS_RATE_LO     6

// reset values
`define BDVS_RST_CODE    6'h00
`define BDVS_RST_MODE    4'h8
`define BDVS_RST_RATE    2'h1
`define BDVS_RST_FREQ    2'h0
`define BDVS_RST_PHASES  8'he4
`define BDVS_FREQ_RSVD   2'h3

// channel one voltage coding
`define BDVS_CH1_FLOOR   6'h0d
`define BDVS_ANY_FLOOR   6'h00
`define BDVS_MV_BASE     11'h271
`define BDVS_MV_STEP     11'h019

// ramp timing
`define BDVS_CLK_NS      100
`define BDVS_STEP_NS     2000
`define BDVS_BASE_CYC    (`BDVS_STEP_NS / `BDVS_CLK_NS)
`define BDVS_BASE_LAST   5'h13

`endif
